// ### include/cfg_map_pkg.sv
// Constants, register map and types for the device map
package cfg_map_pkg;

    // Register bus geometry
    localparam int AXI_ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CFG_ADDR = 8'h00;
    localparam logic [7:0] OFS_CFG_DATA = 8'h04;
    localparam logic [7:0] OFS_CTRL = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0c;
    localparam logic [7:0] OFS_STICKY = 8'h10;
    localparam logic [7:0] OFS_BUF_SEL = 8'h14;

    // Config address layout
    localparam int CA_EN = 31;
    localparam int CA_BUS_HI = 23;
    localparam int CA_BUS_LO = 16;
    localparam int CA_DEV_HI = 15;
    localparam int CA_DEV_LO = 11;
    localparam int CA_FN_HI = 10;
    localparam int CA_FN_LO = 8;
    localparam int CA_REG_HI = 7;
    localparam int CA_REG_LO = 2;
    localparam logic [31:0] CA_KEEP_MASK = 32'h80ff_fffc;
    localparam logic [31:0] CA_RESET = 32'h0000_0000;
    localparam logic [7:0] BUS_ZERO = 8'h00;

    // Control register fields
    localparam int CTRL_MERGE23 = 0;
    localparam int CTRL_MERGE45 = 1;
    localparam int CTRL_MERGE67 = 2;
    localparam int CTRL_X16 = 3;
    localparam int CTRL_LOCK = 8;

    // Sticky register fields
    localparam int SK_ABORT = 0;
    localparam int SK_RSVD = 1;

    // Device numbers on bus 0
    localparam logic [4:0] DEV_HUB = 5'h00;
    localparam logic [4:0] DEV_P2 = 5'h02;
    localparam logic [4:0] DEV_P3 = 5'h03;
    localparam logic [4:0] DEV_P4 = 5'h04;
    localparam logic [4:0] DEV_P5 = 5'h05;
    localparam logic [4:0] DEV_P6 = 5'h06;
    localparam logic [4:0] DEV_P7 = 5'h07;
    localparam logic [4:0] DEV_BUF = 5'h09;
    localparam logic [4:0] DEV_FSB = 5'h10;
    localparam logic [4:0] DEV_CE = 5'h11;
    localparam logic [4:0] DEV_DBG = 5'h13;
    localparam logic [4:0] DEV_BR0 = 5'h15;
    localparam logic [4:0] DEV_BR1 = 5'h16;

    // Register group indices
    localparam int NUM_FN = 15;
    localparam int IDX_W = 4;
    localparam logic [3:0] FN_HUB = 4'h0;
    localparam logic [3:0] FN_P2 = 4'h1;
    localparam logic [3:0] FN_P3 = 4'h2;
    localparam logic [3:0] FN_P4 = 4'h3;
    localparam logic [3:0] FN_P5 = 4'h4;
    localparam logic [3:0] FN_P6 = 4'h5;
    localparam logic [3:0] FN_P7 = 4'h6;
    localparam logic [3:0] FN_BUF = 4'h7;
    localparam logic [3:0] FN_FSB0 = 4'h8;
    localparam logic [3:0] FN_FSB1 = 4'h9;
    localparam logic [3:0] FN_FSB2 = 4'ha;
    localparam logic [3:0] FN_CE = 4'hb;
    localparam logic [3:0] FN_DBG = 4'hc;
    localparam logic [3:0] FN_BR0 = 4'hd;
    localparam logic [3:0] FN_BR1 = 4'he;

    // Identification codes: all values arbitrary
    localparam logic [15:0] VENDOR_CODE = 16'h1a5e;
    localparam logic [15:0] ID_HUB = 16'h7000;
    localparam logic [15:0] ID_X4_BASE = 16'h7010;
    localparam logic [15:0] ID_X8_BASE = 16'h7020;
    localparam logic [15:0] ID_X16 = 16'h7030;
    localparam logic [15:0] ID_MISC_BASE = 16'h7040;

    // Answers
    localparam logic [31:0] ALL_ONES = 32'hffff_ffff;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Bus handshake states
    typedef enum logic [1:0] {WS_IDLE = 2'b01, WS_RESP = 2'b10} wstate_t;
    typedef enum logic [1:0] {RS_IDLE = 2'b01, RS_DATA = 2'b10} rstate_t;

endpackage

// ### logic/cfg_target_decode.sv
// Bus 0 device and function decode onto group indices
`timescale 1ns/1ps
module cfg_target_decode
(
    input wire logic [31:0] addr_i,
    input wire logic [2:0] merge_i,
    input wire logic x16_i,
    output logic hit_o,
    output logic [cfg_map_pkg::IDX_W-1:0] idx_o
);
    import cfg_map_pkg::*;

    logic [4:0] dev; // Device number field
    logic [2:0] fn; // Function number field
    logic fn0; // Function zero addressed

    assign dev = addr_i[CA_DEV_HI:CA_DEV_LO];
    assign fn = addr_i[CA_FN_HI:CA_FN_LO];
    assign fn0 = (fn == 3'h0);

    // Route each implemented device, others miss
    always_comb
    begin
        hit_o = 1'b0;
        idx_o = FN_HUB;
        // Only enabled cycles on bus 0 are claimed
        if (addr_i[CA_EN] && addr_i[CA_BUS_HI:CA_BUS_LO] == BUS_ZERO)
        begin
            case (dev)
                DEV_HUB:
                begin
                    hit_o = fn0;
                    idx_o = FN_HUB;
                end
                DEV_P2:
                begin
                    hit_o = fn0; // Also controls merged pair
                    idx_o = FN_P2;
                end
                DEV_P3:
                begin
                    hit_o = fn0 && !merge_i[0];
                    idx_o = FN_P3;
                end
                DEV_P4:
                begin
                    hit_o = fn0;
                    idx_o = FN_P4;
                end
                DEV_P5:
                begin
                    hit_o = fn0 && !merge_i[1] && !x16_i;
                    idx_o = FN_P5;
                end
                DEV_P6:
                begin
                    hit_o = fn0 && !x16_i;
                    idx_o = FN_P6;
                end
                DEV_P7:
                begin
                    hit_o = fn0 && !merge_i[2] && !x16_i;
                    idx_o = FN_P7;
                end
                DEV_BUF:
                begin
                    // Sideband only, never through the window
                    hit_o = 1'b0;
                    idx_o = FN_BUF;
                end
                DEV_FSB:
                begin
                    hit_o = (fn <= 3'h2); // Three functions
                    idx_o = FN_FSB0 + {1'b0, fn};
                end
                DEV_CE:
                begin
                    hit_o = fn0;
                    idx_o = FN_CE;
                end
                DEV_DBG:
                begin
                    hit_o = fn0;
                    idx_o = FN_DBG;
                end
                DEV_BR0:
                begin
                    hit_o = fn0;
                    idx_o = FN_BR0;
                end
                DEV_BR1:
                begin
                    hit_o = fn0;
                    idx_o = FN_BR1;
                end
                default:
                begin
                    hit_o = 1'b0; // Unlisted device numbers
                    idx_o = FN_HUB;
                end
            endcase
        end
    end

endmodule

// ### logic/pci_config_device_map.sv
// Config address/data window and bus 0 device map over AXI4-Lite
//
// Summary of operation
// - Lockable bits become read-only once locked
// - Config address accepts plain full writes
// - Reserved locations complete and read zero
// - Reserved location writes change nothing
// - Reset loads defaults, some from straps
// - Sticky bits cleared only by write-one or power-good reset
// - Thirteen devices exposed on bus 0
// - Only hub devices decoded on bus 0
// - Device 0 function 0 holds hub registers
// - Ports 2/3 merged: device 3 inactive
// - Ports 4/5 merged: device 5 inactive
// - Ports 6/7 merged: device 7 inactive
// - Port identifier follows configured link width
// - Device 9 only through sideband and select
// - Device 16 routes three functions
// - Devices 17 and 19 route function 0
// - Devices 21 and 22 hold branch registers
// - Bus number zero targets bus 0
// - Missing devices abort: drop writes, read ones
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module pci_config_device_map
#(
    parameter int CFG_WORDS = 8, // Implemented words per function
    parameter int BUF_SEL_W = 3 // Width of memory buffer select
)
(
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    input wire logic POWER_GOOD_RESET_N_I,
    input wire logic [2:0] STRAP_MERGE_I,
    input wire logic STRAP_X16_I,
    input wire logic [cfg_map_pkg::AXI_ADDR_W-1:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [cfg_map_pkg::AXI_ADDR_W-1:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic SB_VALID_I,
    input wire logic SB_WRITE_I,
    input wire logic [5:0] SB_OFFSET_I,
    input wire logic [31:0] SB_WDATA_I,
    output logic [31:0] SB_RDATA_O,
    output logic SB_DONE_O,
    output logic [BUF_SEL_W-1:0] BUF_SELECT_O,
    output logic [3:0] PORT_MODE_O
);
    import cfg_map_pkg::*;

    // Byte-lane merge of a write into an old word
    function automatic logic [31:0] merge_bytes(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Identifier of a group, ports chosen by link width
    function automatic logic [15:0] id_of(input logic [3:0] idx,
        input logic [2:0] mrg, input logic x16);
        logic [15:0] id;
        unique case (idx)
            FN_HUB: id = ID_HUB;
            FN_P2: id = mrg[0] ? ID_X8_BASE : ID_X4_BASE;
            FN_P4: id = x16 ? ID_X16 :
                (mrg[1] ? ID_X8_BASE + 16'h0001 : ID_X4_BASE + 16'h0001);
            FN_P6: id = mrg[2] ? ID_X8_BASE + 16'h0002 :
                ID_X4_BASE + 16'h0002;
            default: id = ID_MISC_BASE + {12'h000, idx};
        endcase
        return id;
    endfunction

    wstate_t wstate; // Write handshake state
    rstate_t rstate; // Read handshake state
    logic aw_held; // Write address taken
    logic w_held; // Write data taken
    logic [7:0] wr_addr; // Latched write address
    logic [31:0] wr_data; // Latched write data
    logic [3:0] wr_strb; // Latched byte enables
    logic do_write; // Write performed this cycle
    logic do_read; // Read address taken this cycle
    logic [31:0] cfg_addr; // Configuration address register
    logic [2:0] merge; // Port pair merge flags
    logic x16; // Port 4 runs x16 over ports 4..7
    logic lock; // Freezes merge and width bits
    logic strap_taken; // Straps captured after release
    logic [BUF_SEL_W-1:0] buf_sel; // Memory buffer select
    logic last_abort; // Last window access aborted
    logic last_rsvd; // Last window access hit reserved
    logic [3:0] last_idx; // Last window target group
    logic [1:0] sticky; // Sticky event flags
    logic hit; // Window target exists
    logic [3:0] idx; // Window target group
    logic [5:0] reg_idx; // Window word index
    logic in_range; // Word index implemented
    logic [31:0] cfg_mem [NUM_FN][CFG_WORDS]; // Per-function words
    logic [31:0] win_rd; // Window read value
    logic [31:0] next_rdata; // Read answer data
    logic [1:0] next_rresp; // Read answer code
    logic win_wr; // Write to window
    logic win_rd_evt; // Read of window
    logic win_evt; // Any window access

    // Map the config address onto a group
    cfg_target_decode u_decode
    (
        .addr_i(cfg_addr),
        .merge_i(merge),
        .x16_i(x16),
        .hit_o(hit),
        .idx_o(idx)
    );

    assign reg_idx = cfg_addr[CA_REG_HI:CA_REG_LO];
    assign in_range = (reg_idx < 6'(CFG_WORDS));
    assign do_write = (wstate == WS_IDLE) && aw_held && w_held;
    assign do_read = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    assign win_wr = do_write && (wr_addr == OFS_CFG_DATA);
    assign win_rd_evt = do_read && (S_AXI_ARADDR_I == OFS_CFG_DATA);
    assign win_evt = win_wr || win_rd_evt;

    // Window read: ones on abort, zero on reserved words
    always_comb
    begin
        win_rd = ALL_ONES;
        if (hit)
        begin
            if (reg_idx == 6'h00)
            begin
                win_rd = {id_of(idx, merge, x16), VENDOR_CODE};
            end
            else if (in_range)
            begin
                win_rd = cfg_mem[idx][reg_idx[2:0]];
            end
            else
            begin
                win_rd = ZERO_WORD;
            end
        end
    end

    // Read answer mux; unmapped offsets get SLVERR
    always_comb
    begin
        next_rdata = ZERO_WORD;
        next_rresp = RESP_OKAY;
        case (S_AXI_ARADDR_I)
            OFS_CFG_ADDR: next_rdata = cfg_addr;
            OFS_CFG_DATA: next_rdata = win_rd;
            OFS_CTRL: next_rdata = {23'h0, lock, 4'h0, x16, merge};
            OFS_STATUS: next_rdata = {24'h0, last_idx, 2'b00,
                last_rsvd, last_abort};
            OFS_STICKY: next_rdata = {30'h0, sticky};
            OFS_BUF_SEL: next_rdata = {{(32-BUF_SEL_W){1'b0}}, buf_sel};
            default: next_rresp = RESP_SLVERR;
        endcase
    end

    // Write channel: AW and W in either order, then response
    always_ff @(posedge REF_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            wstate <= WS_IDLE;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 8'h00;
            wr_data <= ZERO_WORD;
            wr_strb <= 4'h0;
            S_AXI_AWREADY_O <= 1'b0;
            S_AXI_WREADY_O <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= RESP_OKAY;
        end
        else
        begin
            unique case (wstate)
                WS_IDLE:
                begin
                    S_AXI_AWREADY_O <= !aw_held && !(S_AXI_AWVALID_I &&
                        S_AXI_AWREADY_O);
                    S_AXI_WREADY_O <= !w_held && !(S_AXI_WVALID_I &&
                        S_AXI_WREADY_O);
                    if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
                    begin
                        aw_held <= 1'b1;
                        wr_addr <= S_AXI_AWADDR_I;
                    end
                    if (S_AXI_WVALID_I && S_AXI_WREADY_O)
                    begin
                        w_held <= 1'b1;
                        wr_data <= S_AXI_WDATA_I;
                        wr_strb <= S_AXI_WSTRB_I;
                    end
                    if (do_write)
                    begin
                        wstate <= WS_RESP;
                        S_AXI_BVALID_O <= 1'b1;
                        S_AXI_BRESP_O <= (wr_addr > OFS_BUF_SEL ||
                            wr_addr[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
                    end
                end
                WS_RESP:
                begin
                    if (S_AXI_BREADY_I)
                    begin
                        wstate <= WS_IDLE;
                        S_AXI_BVALID_O <= 1'b0;
                        aw_held <= 1'b0;
                        w_held <= 1'b0;
                        S_AXI_AWREADY_O <= 1'b1;
                        S_AXI_WREADY_O <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Read channel: answer one cycle after address take
    always_ff @(posedge REF_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            rstate <= RS_IDLE;
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= ZERO_WORD;
            S_AXI_RRESP_O <= RESP_OKAY;
        end
        else
        begin
            unique case (rstate)
                RS_IDLE:
                begin
                    S_AXI_ARREADY_O <= !do_read;
                    if (do_read)
                    begin
                        rstate <= RS_DATA;
                        S_AXI_RVALID_O <= 1'b1;
                        S_AXI_RDATA_O <= next_rdata;
                        S_AXI_RRESP_O <= next_rresp;
                    end
                end
                RS_DATA:
                begin
                    if (S_AXI_RREADY_I)
                    begin
                        rstate <= RS_IDLE;
                        S_AXI_RVALID_O <= 1'b0;
                        S_AXI_ARREADY_O <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Config address: full words only, reserved bits dropped
    always_ff @(posedge REF_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            cfg_addr <= CA_RESET;
        end
        else if (do_write && wr_addr == OFS_CFG_ADDR && wr_strb == 4'hf)
        begin
            cfg_addr <= wr_data & CA_KEEP_MASK;
        end
    end

    // Control: strap defaults, then lockable writes
    always_ff @(posedge REF_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            merge <= 3'b000;
            x16 <= 1'b0;
            lock <= 1'b0;
            strap_taken <= 1'b0;
            buf_sel <= '0;
        end
        else if (!strap_taken)
        begin
            // Straps caught on the first edge after release
            merge <= STRAP_MERGE_I;
            x16 <= STRAP_X16_I;
            strap_taken <= 1'b1;
        end
        else if (do_write)
        begin
            if (wr_addr == OFS_CTRL && wr_strb[0] && !lock)
            begin
                merge <= wr_data[CTRL_MERGE67:CTRL_MERGE23];
                x16 <= wr_data[CTRL_X16];
            end
            if (wr_addr == OFS_CTRL && wr_strb[1] && wr_data[CTRL_LOCK])
            begin
                lock <= 1'b1; // Only a hard reset unlocks
            end
            if (wr_addr == OFS_BUF_SEL && wr_strb[0])
            begin
                buf_sel <= wr_data[BUF_SEL_W-1:0];
            end
        end
    end

    // Function words; window writes only hit existing words
    always_ff @(posedge REF_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            for (int f = 0; f < NUM_FN; f++)
            begin
                for (int w = 0; w < CFG_WORDS; w++)
                begin
                    cfg_mem[f][w] <= ZERO_WORD;
                end
            end
        end
        else
        begin
            // Abort drops, reserved and word 0 ignore
            if (win_wr && hit && in_range && reg_idx != 6'h00)
            begin
                cfg_mem[idx][reg_idx[2:0]] <= merge_bytes(
                    cfg_mem[idx][reg_idx[2:0]], wr_data, wr_strb);
            end
            // Buffer space via sideband only
            if (SB_VALID_I && SB_WRITE_I && SB_OFFSET_I != 6'h00 &&
                SB_OFFSET_I < 6'(CFG_WORDS))
            begin
                cfg_mem[FN_BUF][SB_OFFSET_I[2:0]] <= SB_WDATA_I;
            end
        end
    end

    // Sideband answer, one cycle after the request
    always_ff @(posedge REF_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            SB_RDATA_O <= ZERO_WORD;
            SB_DONE_O <= 1'b0;
        end
        else
        begin
            SB_DONE_O <= SB_VALID_I;
            if (SB_VALID_I && !SB_WRITE_I)
            begin
                if (SB_OFFSET_I == 6'h00)
                begin
                    SB_RDATA_O <= {id_of(FN_BUF, merge, x16), VENDOR_CODE};
                end
                else if (SB_OFFSET_I < 6'(CFG_WORDS))
                begin
                    SB_RDATA_O <= cfg_mem[FN_BUF][SB_OFFSET_I[2:0]];
                end
                else
                begin
                    SB_RDATA_O <= ZERO_WORD;
                end
            end
        end
    end

    // Last window access status, hard reset domain
    always_ff @(posedge REF_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            last_abort <= 1'b0;
            last_rsvd <= 1'b0;
            last_idx <= 4'h0;
        end
        else if (win_evt)
        begin
            last_abort <= !hit;
            last_rsvd <= hit && !in_range;
            last_idx <= idx;
        end
    end

    // Sticky flags survive hard reset; set beats write-one clear
    always_ff @(posedge REF_CLK_I or negedge POWER_GOOD_RESET_N_I)
    begin
        if (!POWER_GOOD_RESET_N_I)
        begin
            sticky <= 2'b00;
        end
        else
        begin
            sticky[SK_ABORT] <= (sticky[SK_ABORT] && !(do_write &&
                wr_addr == OFS_STICKY && wr_strb[0] && wr_data[SK_ABORT]))
                || (win_evt && !hit);
            sticky[SK_RSVD] <= (sticky[SK_RSVD] && !(do_write &&
                wr_addr == OFS_STICKY && wr_strb[0] && wr_data[SK_RSVD]))
                || (win_evt && hit && !in_range);
        end
    end

    // Select and port mode outputs, registered
    always_ff @(posedge REF_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            BUF_SELECT_O <= '0;
            PORT_MODE_O <= 4'h0;
        end
        else
        begin
            BUF_SELECT_O <= buf_sel;
            PORT_MODE_O <= {x16, merge};
        end
    end

endmodule

// ### verif/cfg_map_asserts.sv
// Read and sideband timing checks
`timescale 1ns/1ps
module cfg_map_asserts
(
    input wire logic REF_CLK_I,
    input wire logic RSTN_I,
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    input wire logic [31:0] S_AXI_RDATA_O,
    input wire logic SB_VALID_I,
    input wire logic SB_DONE_O
);
    logic take; // Read address taken
    assign take = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!RSTN_I);
    sequence rd_take; take; endsequence
    sequence rd_wait; S_AXI_RVALID_O && !S_AXI_RREADY_I; endsequence
    a_read_answer: assert property (rd_take |=> S_AXI_RVALID_O)
        else $error("read not answered");
    a_read_source: assert property
        ($rose(S_AXI_RVALID_O) |-> $past(take))
        else $error("unasked read data");
    a_read_hold: assert property (rd_wait |=> $stable(S_AXI_RDATA_O))
        else $error("read data moved");
    a_read_close: assert property (rd_wait |=> S_AXI_RVALID_O)
        else $error("read valid dropped");
    a_read_end: assert property
        (S_AXI_RVALID_O && S_AXI_RREADY_I |=> !S_AXI_RVALID_O)
        else $error("read valid stuck");
    a_one_read: assert property
        (rd_take ##1 S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("second read accepted");
    a_sb_done: assert property (SB_VALID_I |=> SB_DONE_O)
        else $error("sideband not done");
    a_sb_quiet: assert property (!SB_VALID_I |=> !SB_DONE_O)
        else $error("sideband done unasked");
endmodule
bind pci_config_device_map cfg_map_asserts cfg_map_asserts_inst (.*);

// ### verif/cfg_sideband_model.sv
// Sideband agent for the JTAG and SMBus register path
`timescale 1ns/1ps
module cfg_sideband_model
(
    input wire logic REF_CLK_I,
    output logic SB_VALID_I,
    output logic SB_WRITE_I,
    output logic [5:0] SB_OFFSET_I,
    output logic [31:0] SB_WDATA_I
);
    // Idle at time zero
    initial {SB_VALID_I, SB_WRITE_I, SB_OFFSET_I, SB_WDATA_I} = '0;
    // One valid cycle; data inverted once released
    task req(input logic w, input logic [5:0] o, input logic [31:0] d);
        @(posedge REF_CLK_I);
        {SB_VALID_I, SB_WRITE_I, SB_OFFSET_I, SB_WDATA_I} <= {1'b1, w, o, d};
        @(posedge REF_CLK_I);
        SB_VALID_I <= 1'b0;
        SB_WDATA_I <= ~d;
    endtask
endmodule

// ### verif/tb_pci_config_device_map.sv
// Self-checking bench for the device map
`timescale 1ns/1ps
module tb_pci_config_device_map;
    import cfg_map_pkg::*;
    logic REF_CLK_I = 0, RSTN_I = 0, POWER_GOOD_RESET_N_I = 0;
    logic [2:0] STRAP_MERGE_I = 0, BUF_SELECT_O;
    logic STRAP_X16_I = 0, SB_VALID_I, SB_WRITE_I, SB_DONE_O;
    logic [7:0] S_AXI_AWADDR_I = 0, S_AXI_ARADDR_I = 0;
    logic [31:0] S_AXI_WDATA_I = 0, S_AXI_RDATA_O, SB_WDATA_I, SB_RDATA_O;
    logic [3:0] S_AXI_WSTRB_I = 4'hf, PORT_MODE_O;
    logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
    logic S_AXI_AWVALID_I = 0, S_AXI_WVALID_I = 0, S_AXI_BREADY_I = 0;
    logic S_AXI_ARVALID_I = 0, S_AXI_RREADY_I = 0, S_AXI_AWREADY_O;
    logic S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O, S_AXI_RVALID_O;
    logic [5:0] SB_OFFSET_I;
    logic [31:0] rq[$], sq[$], w1, ev, sid;
    int n_errors = 0, cmp_count = 0;
    // Targets {dev, fn}: hub, p2, p3, p4, dev9, dev16 fn1, dev31
    logic [7:0] tl[7] = '{8'h00, 8'h10, 8'h18, 8'h20, 8'h48, 8'h81, 8'hf8};
    // Identifiers per strap mode; zero: absent
    logic [15:0] et[2][7] = '{'{16'h7000, 16'h7010, 16'h7042, 16'h7011,
        16'h0, 16'h7049, 16'h0}, '{16'h7000, 16'h7020, 16'h0, 16'h7021,
        16'h0, 16'h7049, 16'h0}};
    pci_config_device_map pci_config_device_map_inst (.*);
    cfg_sideband_model cfg_sideband_model_inst (.*);
    initial forever #50 REF_CLK_I = ~REF_CLK_I;
    task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        cmp_count++;
        if (s !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task print_verdict;
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Oldest note against each answer
    always @(posedge REF_CLK_I)
    begin
        if (S_AXI_RVALID_O === 1'b1 && S_AXI_RREADY_I)
            cmp("rdata", rq.pop_front(), S_AXI_RDATA_O);
        if (SB_DONE_O === 1'b1)
            cmp("sb_rdata", sq.pop_front(), SB_RDATA_O);
    end
    // AW and W offered together, each dropped once taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        {ta, tw} = 2'b00;
        @(posedge REF_CLK_I);
        {S_AXI_AWADDR_I, S_AXI_WDATA_I} <= {a, d};
        {S_AXI_AWVALID_I, S_AXI_WVALID_I, S_AXI_BREADY_I} <= 3'b111;
        do
        begin
            @(posedge REF_CLK_I);
            ta |= S_AXI_AWREADY_O;
            tw |= S_AXI_WREADY_O;
            {S_AXI_AWVALID_I, S_AXI_WVALID_I} <= {!ta, !tw};
        end
        while (!(ta && tw));
        while (!S_AXI_BVALID_O) @(posedge REF_CLK_I);
        S_AXI_BREADY_I <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        @(posedge REF_CLK_I);
        {S_AXI_ARADDR_I, S_AXI_ARVALID_I, S_AXI_RREADY_I} <= {a, 2'b11};
        do @(posedge REF_CLK_I); while (!S_AXI_ARREADY_O);
        S_AXI_ARVALID_I <= 1'b0;
        do @(posedge REF_CLK_I); while (!S_AXI_RVALID_O);
        S_AXI_RREADY_I <= 1'b0;
    endtask
    // Full address write, junk in reserved bits
    task ca(input logic [7:0] t, input logic [5:0] r);
        wr(OFS_CFG_ADDR, {8'h80, BUS_ZERO, t, r, 2'b00} |
            ($urandom & ~CA_KEEP_MASK));
    endtask
    task sb(input logic w, input logic [5:0] o, input logic [31:0] d, e);
        sq.push_back(e);
        cfg_sideband_model_inst.req(w, o, d);
        @(posedge REF_CLK_I);
    endtask
    initial
    begin
        repeat (20000) @(posedge REF_CLK_I);
        n_errors++;
        print_verdict;
    end
    initial
    begin
        void'($urandom(47));
        sid = {ID_MISC_BASE + 16'h7, VENDOR_CODE};
        for (int k = 0; k < 2; k++)
        begin
            RSTN_I <= 1'b0;
            STRAP_MERGE_I <= {3{k[0]}};
            repeat (6) @(posedge REF_CLK_I);
            {RSTN_I, POWER_GOOD_RESET_N_I} <= 2'b11;
            repeat (2) @(posedge REF_CLK_I);
            rd(OFS_STICKY, {30'h0, {2{k[0]}}});
            for (int i = 0; i < 7; i++)
            begin
                ev = et[k][i] !== 16'h0 ? {et[k][i], VENDOR_CODE} : ALL_ONES;
                ca(tl[i], 6'h0);
                rd(OFS_CFG_DATA, ev);
            end
            w1 = $urandom;
            ca(8'h00, 6'h1);
            wr(OFS_CFG_DATA, w1);
            ca(8'h00, 6'h14);
            wr(OFS_CFG_DATA, ~w1);
            rd(OFS_CFG_DATA, ZERO_WORD);
            ca(8'h00, 6'h1);
            rd(OFS_CFG_DATA, w1);
            sb(1'b0, 6'h0, w1, sid);
            sb(1'b1, 6'h2, w1, sid);
            sb(1'b0, 6'h2, 32'h0, w1);
        end
        wr(OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h100);
        wr(OFS_CTRL, 32'h7);
        rd(OFS_CTRL, 32'h100);
        POWER_GOOD_RESET_N_I <= 1'b0;
        @(posedge REF_CLK_I);
        POWER_GOOD_RESET_N_I <= 1'b1;
        rd(OFS_STICKY, ZERO_WORD);
        @(posedge REF_CLK_I);
        print_verdict;
    end
endmodule
